// [rtl/gfm_top.sv]
// Top of the general purpose pin function mapping block, pins 6 to 11
// Overview of operation
// - Low seven map bits select one bit of the control or status table.
// - Bit seven picks role: zero control input, one status output.
// - Control and status tables each hold 128 bits.
// - All six map registers reset to zero, making every pin a control input on control bit 0.
`default_nettype none
module gfm_top
    import gfm_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Host register port
    input wire gfm_pkg::gfm_host_req_t host_req_in,
    output logic [7:0] host_rdata_out,
    output logic host_rvalid_out,
    // Tables
    input wire logic [127:0] status_table_in,
    output logic [127:0] control_table_out,
    // Pins 6 to 11, index 0 is pin 6
    input wire logic [5:0] pin_in,
    output logic [5:0] pin_out,
    output logic [5:0] pin_oe_out
);
    // Write strobes, one per map register
    logic pin6_wr_w;
    logic pin7_wr_w;
    logic pin8_wr_w;
    logic pin9_wr_w;
    logic pin10_wr_w;
    logic pin11_wr_w;

    // Map register contents as held in each pin slice
    gfm_map_t pin6_map_w;
    gfm_map_t pin7_map_w;
    gfm_map_t pin8_map_w;
    gfm_map_t pin9_map_w;
    gfm_map_t pin10_map_w;
    gfm_map_t pin11_map_w;

    // Register fields of each map
    logic [6:0] pin6_bit_index;
    logic pin6_role_select;
    logic [6:0] pin7_bit_index;
    logic pin7_role_select;
    logic [6:0] pin8_bit_index;
    logic pin8_role_select;
    logic [6:0] pin9_bit_index;
    logic pin9_role_select;
    logic [6:0] pin10_bit_index;
    logic pin10_role_select;
    logic [6:0] pin11_bit_index;
    logic pin11_role_select;

    // Control table contributions and the bits they claim
    logic [127:0] pin6_ctrl_w;
    logic [127:0] pin7_ctrl_w;
    logic [127:0] pin8_ctrl_w;
    logic [127:0] pin9_ctrl_w;
    logic [127:0] pin10_ctrl_w;
    logic [127:0] pin11_ctrl_w;
    logic [127:0] pin6_mask_w;
    logic [127:0] pin7_mask_w;
    logic [127:0] pin8_mask_w;
    logic [127:0] pin9_mask_w;
    logic [127:0] pin10_mask_w;
    logic [127:0] pin11_mask_w;

    logic [127:0] control_table_nxt;
    logic [7:0] rdata_nxt;

    // Writes to offsets outside the six map registers are dropped
    assign pin6_wr_w = host_req_in.wr_en && (host_req_in.addr == GFM_PIN6_OFS);
    assign pin7_wr_w = host_req_in.wr_en && (host_req_in.addr == GFM_PIN7_OFS);
    assign pin8_wr_w = host_req_in.wr_en && (host_req_in.addr == GFM_PIN8_OFS);
    assign pin9_wr_w = host_req_in.wr_en && (host_req_in.addr == GFM_PIN9_OFS);
    assign pin10_wr_w = host_req_in.wr_en && (host_req_in.addr == GFM_PIN10_OFS);
    assign pin11_wr_w = host_req_in.wr_en && (host_req_in.addr == GFM_PIN11_OFS);

    gfm_pin_slice u_pin6 (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .wr_sel_in(pin6_wr_w),
        .wdata_in(host_req_in.wdata),
        .map_out(pin6_map_w),
        .status_table_in(status_table_in),
        .pin_in(pin_in[0]),
        .pin_out(pin_out[0]),
        .pin_oe_out(pin_oe_out[0]),
        .ctrl_bit_out(pin6_ctrl_w),
        .ctrl_mask_out(pin6_mask_w)
    );

    gfm_pin_slice u_pin7 (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .wr_sel_in(pin7_wr_w),
        .wdata_in(host_req_in.wdata),
        .map_out(pin7_map_w),
        .status_table_in(status_table_in),
        .pin_in(pin_in[1]),
        .pin_out(pin_out[1]),
        .pin_oe_out(pin_oe_out[1]),
        .ctrl_bit_out(pin7_ctrl_w),
        .ctrl_mask_out(pin7_mask_w)
    );

    gfm_pin_slice u_pin8 (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .wr_sel_in(pin8_wr_w),
        .wdata_in(host_req_in.wdata),
        .map_out(pin8_map_w),
        .status_table_in(status_table_in),
        .pin_in(pin_in[2]),
        .pin_out(pin_out[2]),
        .pin_oe_out(pin_oe_out[2]),
        .ctrl_bit_out(pin8_ctrl_w),
        .ctrl_mask_out(pin8_mask_w)
    );

    gfm_pin_slice u_pin9 (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .wr_sel_in(pin9_wr_w),
        .wdata_in(host_req_in.wdata),
        .map_out(pin9_map_w),
        .status_table_in(status_table_in),
        .pin_in(pin_in[3]),
        .pin_out(pin_out[3]),
        .pin_oe_out(pin_oe_out[3]),
        .ctrl_bit_out(pin9_ctrl_w),
        .ctrl_mask_out(pin9_mask_w)
    );

    gfm_pin_slice u_pin10 (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .wr_sel_in(pin10_wr_w),
        .wdata_in(host_req_in.wdata),
        .map_out(pin10_map_w),
        .status_table_in(status_table_in),
        .pin_in(pin_in[4]),
        .pin_out(pin_out[4]),
        .pin_oe_out(pin_oe_out[4]),
        .ctrl_bit_out(pin10_ctrl_w),
        .ctrl_mask_out(pin10_mask_w)
    );

    gfm_pin_slice u_pin11 (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .wr_sel_in(pin11_wr_w),
        .wdata_in(host_req_in.wdata),
        .map_out(pin11_map_w),
        .status_table_in(status_table_in),
        .pin_in(pin_in[5]),
        .pin_out(pin_out[5]),
        .pin_oe_out(pin_oe_out[5]),
        .ctrl_bit_out(pin11_ctrl_w),
        .ctrl_mask_out(pin11_mask_w)
    );

    assign pin6_bit_index = pin6_map_w.bit_index;
    assign pin6_role_select = pin6_map_w.role_select;
    assign pin7_bit_index = pin7_map_w.bit_index;
    assign pin7_role_select = pin7_map_w.role_select;
    assign pin8_bit_index = pin8_map_w.bit_index;
    assign pin8_role_select = pin8_map_w.role_select;
    assign pin9_bit_index = pin9_map_w.bit_index;
    assign pin9_role_select = pin9_map_w.role_select;
    assign pin10_bit_index = pin10_map_w.bit_index;
    assign pin10_role_select = pin10_map_w.role_select;
    assign pin11_bit_index = pin11_map_w.bit_index;
    assign pin11_role_select = pin11_map_w.role_select;

    // Unmapped control bits read zero; pins sharing one bit are ORed
    always_comb
    begin
        control_table_nxt = (pin6_ctrl_w & pin6_mask_w)
            | (pin7_ctrl_w & pin7_mask_w)
            | (pin8_ctrl_w & pin8_mask_w)
            | (pin9_ctrl_w & pin9_mask_w)
            | (pin10_ctrl_w & pin10_mask_w)
            | (pin11_ctrl_w & pin11_mask_w);
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
            control_table_out <= '0;
        else
            control_table_out <= control_table_nxt;
    end

    // Unmapped offsets read zero; a read beside a write sees the old value
    always_comb
    begin
        case (host_req_in.addr)
            GFM_PIN6_OFS: rdata_nxt = {pin6_role_select, pin6_bit_index};
            GFM_PIN7_OFS: rdata_nxt = {pin7_role_select, pin7_bit_index};
            GFM_PIN8_OFS: rdata_nxt = {pin8_role_select, pin8_bit_index};
            GFM_PIN9_OFS: rdata_nxt = {pin9_role_select, pin9_bit_index};
            GFM_PIN10_OFS: rdata_nxt = {pin10_role_select, pin10_bit_index};
            GFM_PIN11_OFS: rdata_nxt = {pin11_role_select, pin11_bit_index};
            default: rdata_nxt = 8'h00;
        endcase
    end

    // Read strobe answered exactly one cycle later
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
            host_rvalid_out <= 1'b0;
        else
            host_rvalid_out <= host_req_in.rd_en;
    end

    // Read data holds until the next read, so a slow host may take it late
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
            host_rdata_out <= 8'h00;
        else if (host_req_in.rd_en)
            host_rdata_out <= rdata_nxt;
    end
endmodule // gfm_top
`default_nettype wire

// [rtl/gfm_pkg.sv]
// Package for the general purpose pin function mapping block
`default_nettype none
package gfm_pkg;
    localparam int GFM_NUM_PINS = 6;
    localparam int GFM_FIRST_PIN = 6;
    localparam int GFM_TABLE_BITS = 128;
    localparam int GFM_IDX_W = 7;
    localparam int GFM_ROLE_BIT = 7;
    localparam int GFM_ADDR_W = 8;
    localparam logic [7:0] GFM_PIN6_OFS = 8'hE6;
    localparam logic [7:0] GFM_PIN7_OFS = 8'hE7;
    localparam logic [7:0] GFM_PIN8_OFS = 8'hE8;
    localparam logic [7:0] GFM_PIN9_OFS = 8'hE9;
    localparam logic [7:0] GFM_PIN10_OFS = 8'hEA;
    localparam logic [7:0] GFM_PIN11_OFS = 8'hEB;
    localparam logic [7:0] GFM_MAP_RESET = 8'h00;
    localparam logic GFM_ROLE_CONTROL = 1'b0;
    localparam logic GFM_ROLE_STATUS = 1'b1;

    typedef struct packed {
        logic role_select;
        logic [6:0] bit_index;
    } gfm_map_t;

    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } gfm_host_req_t;
endpackage
`default_nettype wire

// [rtl/gfm_pin_slice.sv]
// One pin: map register, role decode and status bit selection
`default_nettype none
module gfm_pin_slice
    import gfm_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Register access
    input wire logic wr_sel_in,
    input wire logic [7:0] wdata_in,
    output var gfm_pkg::gfm_map_t map_out,
    // Tables
    input wire logic [127:0] status_table_in,
    // Pin
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe_out,
    output logic [127:0] ctrl_bit_out,
    output logic [127:0] ctrl_mask_out
);
    gfm_map_t map_r;

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
            map_r <= GFM_MAP_RESET;
        else if (wr_sel_in)
            map_r <= wdata_in;
    end

    assign map_out = map_r;

    // Registered so the pin never glitches while the index changes
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pin_out <= 1'b0;
            pin_oe_out <= 1'b0;
        end
        else
        begin
            pin_out <= status_table_in[map_r.bit_index];
            pin_oe_out <= (map_r.role_select == GFM_ROLE_STATUS);
        end
    end

    // One-hot contribution to the control table while in control role
    always_comb
    begin
        ctrl_mask_out = '0;
        ctrl_bit_out = '0;
        if (map_r.role_select == GFM_ROLE_CONTROL)
        begin
            ctrl_mask_out[map_r.bit_index] = 1'b1;
            ctrl_bit_out[map_r.bit_index] = pin_in;
        end
    end
endmodule // gfm_pin_slice
`default_nettype wire

// [tb/gfm_properties.sv]
// Checker for the pin function mapping block
`default_nettype none
module gfm_properties
    import gfm_pkg::*;
(
    // Clock, reset, host
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire gfm_pkg::gfm_host_req_t host_req_in,
    input wire logic [7:0] host_rdata_out,
    input wire logic host_rvalid_out,
    // Tables and pins
    input wire logic [127:0] status_table_in,
    input wire logic [127:0] control_table_out,
    input wire logic [5:0] pin_in,
    input wire logic [5:0] pin_out,
    input wire logic [5:0] pin_oe_out
);
timeunit 1ns;
timeprecision 1ns;
default clocking @(posedge core_clk_in); endclocking
default disable iff (rst_in);
// Shadow of the pin 8 map, since the checker cannot see inside
logic [7:0] m8_r;
always_ff @(posedge core_clk_in or posedge rst_in)
begin
    if (rst_in)
        m8_r <= 8'h00;
    else if (host_req_in.wr_en && host_req_in.addr == GFM_PIN8_OFS)
        m8_r <= host_req_in.wdata;
end
sequence s_rd8;
    host_req_in.rd_en && host_req_in.addr == GFM_PIN8_OFS;
endsequence
chk_read_back: assert property (s_rd8 |=>
    host_rvalid_out && host_rdata_out == $past(m8_r)) else $error("map readback wrong");
chk_oe_role: assert property (pin_oe_out[2] == $past(m8_r[7]))
    else $error("pin role wrong");
chk_status_drive: assert property ($past(m8_r[7]) |->
    pin_out[2] == $past(status_table_in[m8_r[6:0]])) else $error("status bit wrong");
chk_ctrl_feed: assert property (!$past(m8_r[7]) && $past(pin_in[2]) |->
    control_table_out[$past(m8_r[6:0])]) else $error("control bit not set");
chk_reset_clear: assert property ($fell(rst_in) |-> pin_oe_out == 6'h00)
    else $error("pins driven after reset");
endmodule // gfm_properties
bind gfm_top gfm_properties u_chk (.core_clk_in, .rst_in, .host_req_in, .host_rdata_out,
    .host_rvalid_out, .status_table_in, .control_table_out, .pin_in, .pin_out, .pin_oe_out);
`default_nettype wire

// [tb/gfm_board.sv]
// Board model: drives control pins, sees status pins
`default_nettype none
module gfm_board
(
    // Board drive and device pins
    input wire logic [5:0] drive_in,
    input wire logic [5:0] dev_in,
    input wire logic [5:0] oe_in,
    output logic [5:0] level_out
);
    timeunit 1ns;
    timeprecision 1ns;
    assign level_out = (oe_in & dev_in) | (~oe_in & drive_in);
endmodule // gfm_board
`default_nettype wire

// [tb/gfm_top_bench.sv]
// Testbench for the pin function mapping block
`default_nettype none
module gfm_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import gfm_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    gfm_host_req_t req = '0;
    logic [127:0] stat = '0;
    logic [127:0] ctrl;
    logic [7:0] rdata;
    logic [5:0] drv = '0;
    logic [5:0] pins, pout, oe;
    logic rv;
    int miscompares = 0;
    int n_tests = 0;
    always #25 clk = ~clk;
    gfm_top dut (.core_clk_in(clk), .rst_in(rst), .host_req_in(req), .host_rdata_out(rdata),
        .host_rvalid_out(rv), .status_table_in(stat), .control_table_out(ctrl),
        .pin_in(pins), .pin_out(pout), .pin_oe_out(oe));
    gfm_board board (.drive_in(drv), .dev_in(pout), .oe_in(oe), .level_out(pins));
    task automatic chk(input logic [127:0] s, e);
        n_tests++;
        if (s !== e)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t seen %0h expected %0h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk) req <= '{1'b1, 1'b0, a, d};
        @(posedge clk) req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, e);
        @(posedge clk) req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk) req <= '0;
        #1;
        chk(rv, 1'b1);
        chk(rdata, e);
    endtask
    // Two edges of margin beyond the one-edge lag
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic end_of_test();
        $display("Errors %0d of %0d checks", miscompares, n_tests);
        if (miscompares == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) rd(8'(8'hE6 + i), 8'h00);
        for (int i = 0; i < 6; i++) wr(8'(8'hE6 + i), 8'(8'h40 + i));
        wr(8'hEC, 8'h55);
        for (int i = 0; i < 6; i++) rd(8'(8'hE6 + i), 8'(8'h40 + i));
        rd(8'hEC, 8'h00);
        @(posedge clk) drv <= 6'h04;
        settle();
        chk(ctrl, 128'h1 << 66);
        wr(GFM_PIN8_OFS, 8'h85);
        @(posedge clk) stat <= 128'h20;
        settle();
        chk(oe, 6'h04);
        chk(pins[2], 1'b1);
        @(posedge clk) stat <= 128'h1 << 127;
        settle();
        chk(pins[2], 1'b0);
        wr(GFM_PIN8_OFS, 8'hFF);
        wr(GFM_PIN7_OFS, 8'h7F);
        @(posedge clk) drv <= 6'h02;
        settle();
        chk(pins[2], 1'b1);
        chk(ctrl, 128'h1 << 127);
        end_of_test();
    end
    initial
    begin
        #20000;
        miscompares++;
        end_of_test();
    end
endmodule // gfm_top_bench
`default_nettype wire
